/* File: verilog/serial_dac_cfg.svh */
// constants shared by both ends of the dual-channel serial converter link
`ifndef SERIAL_DAC_CFG_SVH
`define SERIAL_DAC_CFG_SVH

// ==========================================================================
// word format
`define SAMPLE_W 16
`define BIT_CNT_W 5
`define CHANNELS 2
`define CH_LEFT 0
`define CH_RIGHT 1

// ==========================================================================
// core clock and link timing
`define CORE_CLK_KHZ 125000
`define MIN_BIT_CLK_KHZ 13500
// shortest bit period the device must cope with, rounded down
`define MIN_BIT_CYCLES (`CORE_CLK_KHZ / `MIN_BIT_CLK_KHZ)
// two sync stages plus edge detect need at least this many cycles per level
`define MIN_LEVEL_CYCLES 2
`define HALF_BIT_CYCLES 4
`define LOAD_LOW_CYCLES (2 * `HALF_BIT_CYCLES)
`define WORD_RATE_HZ 352800
`define WORD_CYCLES ((`CORE_CLK_KHZ * 1000) / `WORD_RATE_HZ)
`define DIV_W 8
`define WORD_TMR_W 16
`define IDLE_LIMIT 255
`define PERIOD_W 8

`endif

/* File: verilog/serial_dac_pkg.sv */
// types shared by both ends of the dual-channel serial converter link
`include "serial_dac_cfg.svh"

package serial_dac_pkg;

  typedef logic [`SAMPLE_W-1:0] sample_t;
  typedef logic [`BIT_CNT_W-1:0] bit_cnt_t;

  // one snapshot of the five link lines
  typedef struct packed {
    logic bit_clk;
    logic left_serial_in;
    logic right_serial_in;
    logic left_load_strobe;
    logic right_load_strobe;
  } link_pins_s;

  typedef struct packed {
    link_pins_s meta;
    link_pins_s sync;
    link_pins_s prev;
    sample_t [`CHANNELS-1:0] shreg;
    sample_t [`CHANNELS-1:0] latch;
    bit_cnt_t [`CHANNELS-1:0] bits;
    logic [`CHANNELS-1:0] loaded;
    logic [`CHANNELS-1:0] update;
    logic [`CHANNELS-1:0] short_word;
    logic [`CHANNELS-1:0] long_word;
    logic joint_update;
    logic [`PERIOD_W-1:0] period;
    logic clk_active;
    logic clk_too_fast;
  } receiver_state_s;

  typedef enum logic [1:0] {
    S_IDLE,
    S_WAIT,
    S_SHIFT,
    S_LOAD
  } sender_state_e;

  typedef struct packed {
    sender_state_e state;
    logic [`DIV_W-1:0] div;
    logic [`WORD_TMR_W-1:0] word_timer;
    bit_cnt_t nbits;
    sample_t shreg;
    sample_t hold;
    logic second;
    logic share_strobe;
    logic share_data;
    logic ready;
    logic busy;
    logic bit_clk;
    logic left_data;
    logic right_data;
    logic filter_word_rate_out;
    logic left_strobe;
    logic right_strobe;
  } sender_state_s;

endpackage : serial_dac_pkg

/* File: verilog/serial_dac_if.sv */
// link lines between the interpolation filter and the dual converter input
`timescale 1ns/100ps

interface serial_dac_if;
  logic bit_clk;
  logic left_serial_in;
  logic right_serial_in;
  logic left_load_strobe;
  logic right_load_strobe;

  modport sender (
    output bit_clk,
    output left_serial_in,
    output right_serial_in,
    output left_load_strobe,
    output right_load_strobe
  );

  modport device (
    input bit_clk,
    input left_serial_in,
    input right_serial_in,
    input left_load_strobe,
    input right_load_strobe
  );
endinterface : serial_dac_if

/* File: verilog/serial_dac_sender.sv */
// filter end: serialises stereo samples and drives clock, data and strobes
`timescale 1ns/100ps
`include "serial_dac_cfg.svh"

module serial_dac_sender #(
  parameter int HALF_BIT = `HALF_BIT_CYCLES,
  parameter int WORD_PERIOD = `WORD_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // sample stream
  input wire logic sample_valid,
  input wire serial_dac_pkg::sample_t left_sample,
  input wire serial_dac_pkg::sample_t right_sample,
  output logic sample_ready,
  // wiring options
  input wire logic share_strobe,
  input wire logic share_data,
  // status
  output logic busy,
  // link
  serial_dac_if.sender link
);
  import serial_dac_pkg::*;

  localparam logic [`DIV_W-1:0] HALF_LOAD = `DIV_W'(HALF_BIT - 1);
  localparam logic [`DIV_W-1:0] LOW_LOAD = `DIV_W'(2 * HALF_BIT - 1);
  localparam logic [`WORD_TMR_W-1:0] WORD_LOAD = `WORD_TMR_W'(WORD_PERIOD - 1);
  localparam bit_cnt_t FULL_WORD = `BIT_CNT_W'(`SAMPLE_W);

  sender_state_s q;
  sender_state_s d;
  logic tick;

  // ========================================================================
  // sequencer
  always_comb
  begin
    d = q;
    tick = (q.word_timer == '0);
    d.word_timer = tick ? WORD_LOAD : q.word_timer - `WORD_TMR_W'(1);
    if (q.div != '0)
    begin
      d.div = q.div - `DIV_W'(1);
    end
    case (q.state)
      S_IDLE:
      begin
        d.ready = 1'b1;
        d.busy = 1'b0;
        if (sample_valid && q.ready)
        begin
          d.ready = 1'b0;
          d.busy = 1'b1;
          d.shreg = left_sample;
          d.hold = right_sample;
          d.share_strobe = share_strobe;
          d.share_data = share_data;
          d.state = S_WAIT;
        end
      end
      // words leave only at the word rate tick, except a right word sent second on a shared data line
      S_WAIT:
      begin
        if (tick)
        begin
          d.state = S_SHIFT;
          d.bit_clk = 1'b0;
          d.div = HALF_LOAD;
          d.nbits = '0;
          d.second = 1'b0;
          d.left_data = q.shreg[`SAMPLE_W-1];
          d.right_data = q.share_data ? q.shreg[`SAMPLE_W-1] : q.hold[`SAMPLE_W-1];
        end
      end
      S_SHIFT:
      begin
        if (q.div == '0)
        begin
          d.div = HALF_LOAD;
          if (!q.bit_clk)
          begin
            d.bit_clk = 1'b1;
            d.nbits = q.nbits + `BIT_CNT_W'(1);
          end
          else if (q.nbits == FULL_WORD)
          begin
            // strobes only drop after the sixteenth rise has been seen
            d.bit_clk = 1'b0;
            d.div = LOW_LOAD;
            d.state = S_LOAD;
            if (q.share_strobe || !q.share_data)
            begin
              d.filter_word_rate_out = 1'b0;
              d.left_strobe = 1'b0;
              d.right_strobe = 1'b0;
            end
            else if (q.second)
            begin
              d.right_strobe = 1'b0;
            end
            else
            begin
              d.left_strobe = 1'b0;
            end
          end
          else
          begin
            // data changes on the falling edge, stable at the rising one
            d.bit_clk = 1'b0;
            d.shreg = {q.shreg[`SAMPLE_W-2:0], 1'b0};
            // shared data keeps the right word intact for the second pass
            if (!q.share_data)
            begin
              d.hold = {q.hold[`SAMPLE_W-2:0], 1'b0};
            end
            d.left_data = q.shreg[`SAMPLE_W-2];
            d.right_data = q.share_data ? q.shreg[`SAMPLE_W-2] : q.hold[`SAMPLE_W-2];
          end
        end
      end
      S_LOAD:
      begin
        if (q.div == '0)
        begin
          d.filter_word_rate_out = 1'b1;
          d.left_strobe = 1'b1;
          d.right_strobe = 1'b1;
          // one shared data line with separate strobes: right word follows the left on the same wire
          if (q.share_data && !q.share_strobe && !q.second)
          begin
            d.second = 1'b1;
            d.shreg = q.hold;
            d.nbits = '0;
            d.div = HALF_LOAD;
            d.left_data = q.hold[`SAMPLE_W-1];
            d.right_data = q.hold[`SAMPLE_W-1];
            d.state = S_SHIFT;
          end
          else
          begin
            d.state = S_IDLE;
          end
        end
      end
      default:
      begin
        d.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      q <= '{state: S_IDLE, filter_word_rate_out: 1'b1, left_strobe: 1'b1,
             right_strobe: 1'b1, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // ========================================================================
  // outputs
  assign sample_ready = q.ready;
  assign busy = q.busy;
  assign link.bit_clk = q.bit_clk;
  assign link.left_serial_in = q.left_data;
  assign link.right_serial_in = q.right_data;
  assign link.left_load_strobe = q.left_strobe;
  assign link.right_load_strobe = q.right_strobe;

endmodule : serial_dac_sender

/* File: verilog/serial_dac_receiver.sv */
// converter end: two serial input registers feeding two holding latches
// Operation
// - separate data and strobe input per channel
// - shift each data line on clock rise
// - strobe fall latches last sixteen bits
// - tied strobes update both channels together
// - tied data lines shift same stream
// - sender sends sixteen-bit two's complement, MSB first
// - one bit clock serves both channels
// - accept bit clock of 13.5 MHz
// - sender loads words at 352.8 kHz
// - sender word clock may drive both strobes
// - separate shift register and holding latch
`timescale 1ns/100ps
`include "serial_dac_cfg.svh"

module serial_dac_receiver (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link
  serial_dac_if.device link,
  // converter words
  output serial_dac_pkg::sample_t left_level,
  output serial_dac_pkg::sample_t right_level,
  output logic left_valid,
  output logic right_valid,
  // update strobes, one cycle each
  output logic left_update,
  output logic right_update,
  output logic joint_update,
  // link health
  output logic left_short_word,
  output logic right_short_word,
  output logic left_long_word,
  output logic right_long_word,
  output logic clk_active,
  output logic clk_too_fast
);
  import serial_dac_pkg::*;

  localparam bit_cnt_t FULL_WORD = `BIT_CNT_W'(`SAMPLE_W);
  localparam logic [`PERIOD_W-1:0] IDLE_MAX = `PERIOD_W'(`IDLE_LIMIT);
  // a rise-to-rise spacing below this cannot be trusted through the sync stages
  localparam logic [`PERIOD_W-1:0] MIN_PERIOD = `PERIOD_W'(2 * `MIN_LEVEL_CYCLES);
  // the fastest required clock still has to fit this check
  localparam int REQUIRED_BIT = `MIN_BIT_CYCLES;

  receiver_state_s q;
  receiver_state_s d;
  // combinational helpers, rebuilt every cycle
  link_pins_s pins_in;
  logic rise;
  logic [`CHANNELS-1:0] data_now;
  logic [`CHANNELS-1:0] fall;

  // ========================================================================
  // pin capture
  // only the meta stage reads these; logic sees the sync stage
  always_comb
  begin
    pins_in.bit_clk = link.bit_clk;
    pins_in.left_serial_in = link.left_serial_in;
    pins_in.right_serial_in = link.right_serial_in;
    pins_in.left_load_strobe = link.left_load_strobe;
    pins_in.right_load_strobe = link.right_load_strobe;
  end

  // ========================================================================
  // edge detection and channel datapath
  always_comb
  begin
    d = q;
    // two stages before any logic sees a pin
    d.meta = pins_in;
    d.sync = q.meta;
    d.prev = q.sync;
    rise = q.sync.bit_clk & ~q.prev.bit_clk;
    data_now[`CH_LEFT] = q.sync.left_serial_in;
    data_now[`CH_RIGHT] = q.sync.right_serial_in;
    fall[`CH_LEFT] = q.prev.left_load_strobe & ~q.sync.left_load_strobe;
    fall[`CH_RIGHT] = q.prev.right_load_strobe & ~q.sync.right_load_strobe;
    // channels share only the bit clock; strobes and data stay apart
    for (int ch = 0; ch < `CHANNELS; ch++)
    begin
      d.update[ch] = 1'b0;
      d.short_word[ch] = 1'b0;
      d.long_word[ch] = 1'b0;
      if (rise)
      begin
        // shifting touches only the input register, never the latch
        d.shreg[ch] = {q.shreg[ch][`SAMPLE_W-2:0], data_now[ch]};
        if (q.bits[ch] != '1)
        begin
          d.bits[ch] = q.bits[ch] + `BIT_CNT_W'(1);
        end
      end
      if (fall[ch])
      begin
        // a rise in the same cycle counts as the newest bit
        d.latch[ch] = d.shreg[ch];
        d.loaded[ch] = 1'b1;
        d.update[ch] = 1'b1;
        d.short_word[ch] = (d.bits[ch] < FULL_WORD);
        // extra bits are legal: the oldest simply fall off the top
        d.long_word[ch] = (d.bits[ch] > FULL_WORD);
        d.bits[ch] = '0;
      end
    end
    // both strobes tied to one line fall in the same cycle
    d.joint_update = fall[`CH_LEFT] & fall[`CH_RIGHT];
  end

  // ========================================================================
  // bit clock monitor
  logic [`PERIOD_W-1:0] period_next;
  logic active_next;
  logic fast_next;

  // spacing in core cycles between detected rises, held at the idle limit
  always_comb
  begin
    period_next = q.period;
    active_next = q.clk_active;
    fast_next = q.clk_too_fast;
    if (rise)
    begin
      // sticky once a too-short bit period has been seen
      if (q.clk_active && (q.period < MIN_PERIOD))
      begin
        fast_next = 1'b1;
      end
      period_next = '0;
      active_next = 1'b1;
    end
    else if (q.period != IDLE_MAX)
    begin
      period_next = q.period + `PERIOD_W'(1);
    end
    else
    begin
      // a link clock may stop between frames; this only reports it
      active_next = 1'b0;
    end
  end

  // ========================================================================
  // state register
  // monitor fields override the datapath copy
  receiver_state_s q_next;

  always_comb
  begin
    q_next = d;
    q_next.period = period_next;
    q_next.clk_active = active_next;
    q_next.clk_too_fast = fast_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // latches start at zero but stay flagged invalid until loaded
      q <= '{
        meta: '{default: 1'b1},
        sync: '{default: 1'b1},
        prev: '{default: 1'b1},
        default: '0
      };
    end
    else
    begin
      q <= q_next;
    end
  end

  // ========================================================================
  // outputs, all straight from state
  // holding latches and their valid flags
  assign left_level = q.latch[`CH_LEFT];
  assign right_level = q.latch[`CH_RIGHT];
  assign left_valid = q.loaded[`CH_LEFT];
  assign right_valid = q.loaded[`CH_RIGHT];

  // one-cycle update pulses
  assign left_update = q.update[`CH_LEFT];
  assign right_update = q.update[`CH_RIGHT];
  assign joint_update = q.joint_update;

  // link health
  assign left_short_word = q.short_word[`CH_LEFT];
  assign right_short_word = q.short_word[`CH_RIGHT];
  assign left_long_word = q.long_word[`CH_LEFT];
  assign right_long_word = q.long_word[`CH_RIGHT];
  assign clk_active = q.clk_active;
  assign clk_too_fast = q.clk_too_fast;

  // the fastest clock that must be accepted leaves margin over the check
  if (REQUIRED_BIT < 2 * `MIN_LEVEL_CYCLES)
  begin : g_rate_limit
    $error("core clock too slow for required bit clock");
  end

endmodule : serial_dac_receiver

/* File: tb/serial_dac_assertions.sv */
// wire-level checker for the link between the two converter ends
`timescale 1ns/100ps

module serial_dac_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link
  input wire logic bit_clk,
  input wire logic left_serial_in,
  input wire logic right_serial_in,
  input wire logic left_load_strobe,
  input wire logic right_load_strobe
);
  // ==========================================================================
  // bit clock rises since the last load, saturating
  logic [4:0] rises_q;

  always_ff @(posedge core_clk)
  begin
    if (rst || $fell(left_load_strobe) || $fell(right_load_strobe))
      rises_q <= 5'h00;
    else if ($rose(bit_clk) && rises_q != 5'h1F)
      rises_q <= rises_q + 5'h01;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // link rules
  chk_left_word_bits: assert property (
    $fell(left_load_strobe) |-> rises_q == 5'h10)
    else $error("left strobe fell after wrong bit count");
  chk_right_word_bits: assert property (
    $fell(right_load_strobe) |-> rises_q == 5'h10)
    else $error("right strobe fell after wrong bit count");
  chk_left_load_len: assert property (
    $fell(left_load_strobe) |-> !left_load_strobe[*8] ##1 left_load_strobe)
    else $error("left strobe low time wrong");
  chk_right_load_len: assert property (
    $fell(right_load_strobe) |-> !right_load_strobe[*8] ##1 right_load_strobe)
    else $error("right strobe low time wrong");
  chk_clk_high_len: assert property (
    $rose(bit_clk) |-> bit_clk[*4] ##1 !bit_clk)
    else $error("bit clock high time wrong");
  chk_clk_low_len: assert property (
    $fell(bit_clk) |-> !bit_clk[*4])
    else $error("bit clock low time too short");
  chk_data_steady: assert property (
    bit_clk |-> $stable({left_serial_in, right_serial_in}))
    else $error("data moved while bit clock high");
  chk_clk_still_load: assert property (
    (!left_load_strobe || !right_load_strobe) |-> !bit_clk)
    else $error("bit clock high during a load");
  chk_load_after_word: assert property (
    $fell(bit_clk) && rises_q == 5'h10
      |-> ##[0:2] ($fell(left_load_strobe) || $fell(right_load_strobe)))
    else $error("no load after a full word");
endmodule : serial_dac_assertions

/* File: tb/dual_serial_dac_input_port_tb.sv */
// self-checking bench for both ends of the dual serial converter link
`timescale 1ns/100ps

module dual_serial_dac_input_port_tb;
  import serial_dac_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sample_valid = 1'b0;
  sample_t left_sample = 16'h0000;
  sample_t right_sample = 16'h0000;
  logic share_strobe = 1'b0;
  logic share_data = 1'b0;
  logic sample_ready;
  logic busy;
  sample_t left_level;
  sample_t right_level;
  logic left_valid;
  logic right_valid;
  logic left_update;
  logic right_update;
  logic joint_update;
  logic left_short_word;
  logic right_short_word;
  logic left_long_word;
  logic right_long_word;
  logic clk_active;
  logic clk_too_fast;
  sample_t wire_l;
  sample_t wire_r;
  int errors = 0;
  int n_compared = 0;
  int tl;
  int tr;
  logic jt;

  serial_dac_if lnk ();

  serial_dac_sender serial_dac_sender_i (.core_clk(core_clk), .rst(rst),
    .sample_valid(sample_valid), .left_sample(left_sample), .right_sample(right_sample),
    .sample_ready(sample_ready), .share_strobe(share_strobe), .share_data(share_data),
    .busy(busy), .link(lnk));

  serial_dac_receiver serial_dac_receiver_i (.core_clk(core_clk), .rst(rst), .link(lnk),
    .left_level(left_level), .right_level(right_level), .left_valid(left_valid),
    .right_valid(right_valid), .left_update(left_update), .right_update(right_update),
    .joint_update(joint_update), .left_short_word(left_short_word),
    .right_short_word(right_short_word), .left_long_word(left_long_word),
    .right_long_word(right_long_word), .clk_active(clk_active),
    .clk_too_fast(clk_too_fast));

  serial_dac_assertions serial_dac_assertions_i (.core_clk(core_clk), .rst(rst),
    .bit_clk(lnk.bit_clk), .left_serial_in(lnk.left_serial_in),
    .right_serial_in(lnk.right_serial_in), .left_load_strobe(lnk.left_load_strobe),
    .right_load_strobe(lnk.right_load_strobe));

  always #4 core_clk = ~core_clk;

  // last sixteen bits seen on each data line, independent of the receiver
  always @(posedge lnk.bit_clk)
  begin
    wire_l <= {wire_l[14:0], lnk.left_serial_in};
    wire_r <= {wire_r[14:0], lnk.right_serial_in};
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic send(input sample_t l, input sample_t r, input logic sd, input logic ss);
    int n;
    @(negedge core_clk);
    left_sample = l;
    right_sample = r;
    share_data = sd;
    share_strobe = ss;
    sample_valid = 1'b1;
    for (n = 0; n < 1000 && sample_ready !== 1'b1; n++)
      @(negedge core_clk);
    chk("sample_ready", 16'h0001, sample_ready);
    @(negedge core_clk);
    sample_valid = 1'b0;
    chk("busy", 16'h0001, busy);
  endtask : send

  // cycle index of each update pulse; a word may wait a full word tick first
  task automatic wait_upd();
    int n;
    tl = -1;
    tr = -1;
    jt = 1'b0;
    for (n = 0; n < 1500 && (tl < 0 || tr < 0); n++)
    begin
      @(negedge core_clk);
      if (left_update === 1'b1)
        tl = n;
      if (right_update === 1'b1)
        tr = n;
      if (joint_update === 1'b1)
        jt = 1'b1;
    end
  endtask : wait_upd

  // ==========================================================================
  // scenarios
  task automatic test_reset();
    repeat (2) @(negedge core_clk);
    chk("left_valid", 16'h0000, left_valid);
    chk("right_valid", 16'h0000, right_valid);
    chk("busy", 16'h0000, busy);
    chk("sample_ready", 16'h0001, sample_ready);
    $display("reset test done");
  endtask : test_reset

  task automatic test_separate();
    send(16'h8001, 16'h7FFE, 1'b0, 1'b0);
    wait_upd();
    chk("wire left", 16'h8001, wire_l);
    chk("wire right", 16'h7FFE, wire_r);
    chk("left_level", 16'h8001, left_level);
    chk("right_level", 16'h7FFE, right_level);
    chk("joint_update", 16'h0001, jt);
    chk("left_valid", 16'h0001, left_valid);
    chk("right_valid", 16'h0001, right_valid);
    chk("short/long", 16'h0000, {left_short_word, right_short_word,
      left_long_word, right_long_word});
    $display("separate lines test done");
  endtask : test_separate

  task automatic test_hold();
    send(16'h7FFF, 16'h8000, 1'b0, 1'b0);
    repeat (8) @(posedge lnk.bit_clk);
    @(negedge core_clk);
    chk("left held", 16'h8001, left_level);
    chk("right held", 16'h7FFE, right_level);
    wait_upd();
    chk("left_level", 16'h7FFF, left_level);
    chk("right_level", 16'h8000, right_level);
    $display("hold test done");
  endtask : test_hold

  task automatic test_shared_data();
    send(16'h4C3A, 16'hB5A1, 1'b1, 1'b0);
    wait_upd();
    chk("left first", 16'h0001, tl >= 0 && tl < tr);
    chk("joint_update", 16'h0000, jt);
    chk("left_level", 16'h4C3A, left_level);
    chk("right_level", 16'hB5A1, right_level);
    chk("wire right", 16'hB5A1, wire_r);
    chk("right_long_word", 16'h0001, right_long_word);
    $display("shared data test done");
  endtask : test_shared_data

  task automatic test_shared_both();
    send(16'h0001, 16'h5555, 1'b1, 1'b1);
    wait_upd();
    chk("same cycle", 16'h0001, tl == tr);
    chk("joint_update", 16'h0001, jt);
    chk("left_level", 16'h0001, left_level);
    chk("right_level", 16'h0001, right_level);
    chk("clk_active", 16'h0001, clk_active);
    chk("clk_too_fast", 16'h0000, clk_too_fast);
    chk("short/long both", 16'h0002, {left_short_word, right_short_word,
      left_long_word, right_long_word});
    $display("shared strobe test done");
  endtask : test_shared_both

  // ==========================================================================
  // run control
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // four words at under 700 cycles each, with ample margin
  initial
  begin
    #(8 * 8000);
    errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    complete_run();
  end

  initial
  begin
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    test_reset();
    test_separate();
    test_hold();
    test_shared_data();
    test_shared_both();
    complete_run();
  end
endmodule : dual_serial_dac_input_port_tb
